// ==== hw/fpim_pkg.sv ====
// constants shared by the fieldbus process image mapper
package fpim_pkg;
  // =====================================================
  // image layout
  localparam int unsigned BASIC_IO = 24;
  localparam int unsigned MAX_IO = 128;
  localparam int unsigned IN_BYTES = 16;
  localparam int unsigned OUT_BYTES = 17;
  localparam int unsigned STATUS_BYTE = 3;
  localparam int unsigned BITS_PER_BYTE = 8;
  // =====================================================
  // status byte bit positions
  localparam int unsigned ST_OUT_FAULT = 0;
  localparam int unsigned ST_IN_FAULT = 1;
  localparam int unsigned ST_GFAULT = 2;
  localparam int unsigned ST_DIAGNOSTIC = 3;
  localparam int unsigned ST_RUN = 4;
  localparam int unsigned ST_XCHG = 5;
  localparam int unsigned ST_PAD_LO = 6;
  localparam int unsigned ST_PAD_HI = 7;
  // =====================================================
  // station address
  localparam logic [6:0] ADDR_MAX = 7'h63;
  localparam logic [3:0] DIGIT_MAX = 4'h9;
  localparam logic [6:0] TENS_WEIGHT = 7'h0a;
  localparam logic [6:0] ADDR_RESET = 7'h00;
  // =====================================================
  // start-up timing
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned SETTLE_US = 1000;
  localparam int unsigned SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
  // =====================================================
  // start-up sequence
  typedef enum logic [1:0] {
    FPIM_SETTLE = 2'b00,
    FPIM_CAPTURE = 2'b01,
    FPIM_RUN = 2'b10
  } fpim_state_t;
endpackage

// ==== hw/fpim_addr_capture.sv ====
// station address switch synchroniser and one-shot capture
module fpim_addr_capture
  import fpim_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [3:0] tens_digit_switch,
  input wire logic [3:0] ones_digit_switch,
  input wire logic capture,
  output logic [6:0] station_addr,
  output logic addr_bad
);
  // =====================================================
  // two-stage synchroniser; switches are asynchronous pins
  logic [7:0] sync_a;
  logic [7:0] sync_b;
  logic [3:0] tens;
  logic [3:0] ones;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      sync_a <= 8'h00;
      sync_b <= 8'h00;
    end else begin
      sync_a <= {tens_digit_switch, ones_digit_switch};
      sync_b <= sync_a;
    end
  end

  // a digit above nine is clamped so the address never leaves 0..99
  assign tens = (sync_b[7:4] > DIGIT_MAX) ? DIGIT_MAX : sync_b[7:4];
  assign ones = (sync_b[3:0] > DIGIT_MAX) ? DIGIT_MAX : sync_b[3:0];

  // =====================================================
  // capture once; held until the next reset
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      station_addr <= ADDR_RESET;
      addr_bad <= 1'b0;
    end else if (capture) begin
      station_addr <= 7'(tens * TENS_WEIGHT) + {3'h0, ones};
      addr_bad <= (sync_b[7:4] > DIGIT_MAX) || (sync_b[3:0] > DIGIT_MAX);
    end
  end
endmodule

// ==== hw/fpim_top.sv ====
// fieldbus process image mapper: start-up, address, image mapping, indicators
module fpim_top
  import fpim_pkg::*;
#(
  parameter int unsigned VIO_COUNT = BASIC_IO,
  parameter int unsigned SETTLE_CNT = SETTLE_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [3:0] tens_digit_switch,
  input wire logic [3:0] ones_digit_switch,
  input wire logic [fpim_pkg::IN_BYTES*8-1:0] in_image,
  input wire logic in_image_valid,
  input wire logic dx_active,
  input wire logic link_error,
  input wire logic [VIO_COUNT-1:0] vout,
  input wire logic output_fault_flag,
  input wire logic input_fault_flag,
  input wire logic general_fault_flag,
  input wire logic diagnostic_flag,
  input wire logic run_flag,
  output logic [6:0] station_addr,
  output logic addr_valid,
  output logic slave_enable,
  output logic [VIO_COUNT-1:0] vin,
  output logic [fpim_pkg::OUT_BYTES*8-1:0] out_image,
  output logic led_power,
  output logic led_online,
  output logic led_offline,
  output logic led_fault
);
  import fpim_pkg::*;

  // extended outputs sit one byte higher to step over the status byte
  function automatic int unsigned out_bit_pos(input int unsigned n);
    return (n < BASIC_IO) ? n : n + BITS_PER_BYTE;
  endfunction

  fpim_state_t state;
  logic [31:0] settle_cnt;
  logic capture;
  logic addr_bad;
  logic exchanging;
  logic [OUT_BYTES*8-1:0] next_out_image;

  // =====================================================
  // start-up sequence
  // switches get a settle time before the single sample is taken
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state <= FPIM_SETTLE;
      settle_cnt <= 32'h0000_0000;
    end else begin
      case (state)
        FPIM_SETTLE: begin
          settle_cnt <= settle_cnt + 32'h0000_0001;
          if (settle_cnt >= 32'(SETTLE_CNT - 1)) begin
            state <= FPIM_CAPTURE;
          end
        end
        FPIM_CAPTURE: state <= FPIM_RUN;
        FPIM_RUN: state <= FPIM_RUN;
        default: state <= FPIM_SETTLE;
      endcase
    end
  end

  assign capture = (state == FPIM_CAPTURE);

  fpim_addr_capture u_addr (
    .clock(clock),
    .rst_b(rst_b),
    .tens_digit_switch(tens_digit_switch),
    .ones_digit_switch(ones_digit_switch),
    .capture(capture),
    .station_addr(station_addr),
    .addr_bad(addr_bad)
  );

  // =====================================================
  // slave enable; the protocol core handles every rate, we only release it
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      addr_valid <= 1'b0;
      slave_enable <= 1'b0;
    end else begin
      addr_valid <= addr_valid | capture;
      slave_enable <= slave_enable | capture;
    end
  end

  assign exchanging = slave_enable && dx_active;

  // =====================================================
  // virtual inputs; cleared when exchange stops so stale data never lingers
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      vin <= '0;
    end else if (!exchanging) begin
      vin <= '0;
    end else if (in_image_valid) begin
      for (int unsigned n = 0; n < VIO_COUNT; n++) begin
        vin[n] <= in_image[(n / BITS_PER_BYTE) * BITS_PER_BYTE + n % BITS_PER_BYTE];
      end
    end
  end

  // =====================================================
  // output image assembly
  always_comb begin
    next_out_image = '0;
    for (int unsigned n = 0; n < VIO_COUNT; n++) begin
      next_out_image[out_bit_pos(n)] = vout[n];
    end
    next_out_image[STATUS_BYTE*BITS_PER_BYTE+ST_OUT_FAULT] = output_fault_flag;
    next_out_image[STATUS_BYTE*BITS_PER_BYTE+ST_IN_FAULT] = input_fault_flag;
    next_out_image[STATUS_BYTE*BITS_PER_BYTE+ST_GFAULT] = general_fault_flag;
    next_out_image[STATUS_BYTE*BITS_PER_BYTE+ST_DIAGNOSTIC] = diagnostic_flag;
    next_out_image[STATUS_BYTE*BITS_PER_BYTE+ST_RUN] = run_flag;
    next_out_image[STATUS_BYTE*BITS_PER_BYTE+ST_XCHG] = exchanging;
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      out_image <= '0;
    end else begin
      out_image <= next_out_image;
    end
  end

  // =====================================================
  // indicators
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      led_power <= 1'b0;
      led_online <= 1'b0;
      led_offline <= 1'b0;
      led_fault <= 1'b0;
    end else begin
      led_power <= 1'b1;
      led_online <= exchanging;
      led_offline <= slave_enable && !dx_active;
      led_fault <= addr_bad || link_error;
    end
  end

  // =====================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  // cycles since reset release; saturates so long runs never wrap into a false match
  logic [31:0] up_cnt;
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      up_cnt <= 32'h0000_0000;
    end else if (up_cnt != 32'hffff_ffff) begin
      up_cnt <= up_cnt + 32'h0000_0001;
    end
  end

  // properties, each beside the rule it guards
  addr_range_a: assert property (addr_valid |-> station_addr <= ADDR_MAX)
    else $error("station address above 99");
  auto_start_a: assert property (up_cnt == 32'(SETTLE_CNT + 1) |-> slave_enable)
    else $error("slave not started after settle time");
  start_quiet_a: assert property (up_cnt == 32'(SETTLE_CNT) |->
    !slave_enable && !addr_valid)
    else $error("slave started before the switch sample");
  vin_map_a: assert property (exchanging && in_image_valid |=>
    vin == $past(in_image[VIO_COUNT-1:0]))
    else $error("virtual inputs do not match input image");
  vin_clear_a: assert property (!exchanging |=> vin == '0)
    else $error("virtual inputs not cleared outside exchange");
  out_map_a: assert property (1 |=> out_image[7:0] == $past(vout[7:0]))
    else $error("output byte 0 does not match virtual outputs");
  status_mirror_a: assert property (1 |=>
    out_image[STATUS_BYTE*BITS_PER_BYTE+ST_RUN] == $past(run_flag) &&
    out_image[STATUS_BYTE*BITS_PER_BYTE+ST_OUT_FAULT] == $past(output_fault_flag))
    else $error("status byte does not mirror controller flags");
  status_rest_a: assert property (1 |=>
    out_image[STATUS_BYTE*BITS_PER_BYTE+ST_IN_FAULT] == $past(input_fault_flag) &&
    out_image[STATUS_BYTE*BITS_PER_BYTE+ST_GFAULT] == $past(general_fault_flag) &&
    out_image[STATUS_BYTE*BITS_PER_BYTE+ST_DIAGNOSTIC] == $past(diagnostic_flag))
    else $error("status byte fault and diagnostic bits wrong");
  xchg_flag_a: assert property (!slave_enable |=>
    !out_image[STATUS_BYTE*BITS_PER_BYTE+ST_XCHG])
    else $error("exchange flag set before start");
  pad_zero_a: assert property (1 |=>
    out_image[STATUS_BYTE*BITS_PER_BYTE+ST_PAD_HI -: 2] == 2'b00)
    else $error("status pad bits not zero");
  addr_hold_a: assert property (addr_valid ##1 addr_valid |-> $stable(station_addr))
    else $error("station address changed after capture");
  led_exclusive_a: assert property (led_online |-> !led_offline && led_power)
    else $error("online and offline both lit");
  led_online_a: assert property (1 |=> led_online == $past(exchanging))
    else $error("online indicator does not follow exchange");
  led_fault_a: assert property (1 |=>
    led_fault == ($past(addr_bad) || $past(link_error)))
    else $error("fault indicator does not follow its causes");
  // everything past the last mapped output stays clear; byte 3 pads are checked above
  localparam int unsigned USED_TOP = (VIO_COUNT > BASIC_IO) ?
    VIO_COUNT + BITS_PER_BYTE : (STATUS_BYTE + 1) * BITS_PER_BYTE;
  unused_zero_a: assert property (1 |=> (out_image >> USED_TOP) == '0)
    else $error("unmapped output bits not zero");

  // main scenarios: start-up, exchange, fault, clamped address
  start_seen_c: cover property ($rose(slave_enable));
  exchange_c: cover property (exchanging && in_image_valid ##1 led_online);
  fault_c: cover property (led_fault && slave_enable);
  addr_clamp_c: cover property ($rose(addr_valid) ##1 led_fault);
endmodule

// ==== testbench/fpim_master_model.sv ====
// behavioural model of the protocol core and master feeding the mapper
module fpim_master_model (
  input wire logic clock,
  output logic [127:0] in_image,
  output logic in_image_valid,
  output logic dx_active,
  output logic link_error
);
  timeunit 1ns;
  timeprecision 1ps;
  // =====================================================
  // cyclic frame source
  // idle lines start quiet, frames come only on request
  initial begin
    in_image = 128'h0;
    in_image_valid = 1'b0;
    dx_active = 1'b0;
    link_error = 1'b0;
  end
  // one frame, optionally after some idle cycles to model a slow master
  task automatic send_frame(input logic [127:0] data, input int gap);
    repeat (gap) @(posedge clock);
    @(posedge clock);
    in_image <= data;
    in_image_valid <= 1'b1;
    @(posedge clock);
    in_image_valid <= 1'b0;
    // data no longer valid: show junk so stale values never look right
    in_image <= ~data;
  endtask
  // exchange state and link health as reported by the core
  task automatic set_link(input logic dx, input logic err);
    @(posedge clock);
    dx_active <= dx;
    link_error <= err;
  endtask
endmodule

// ==== testbench/fpim_tb_top.sv ====
// self-checking testbench for the fieldbus process image mapper
module fpim_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fpim_pkg::*;
  // =====================================================
  // stimulus and observed signals
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] tens_sw = 4'h3;
  logic [3:0] ones_sw = 4'h6;
  logic [23:0] vout = 24'h000000;
  logic [4:0] flag = 5'h00;
  logic [127:0] in_image;
  logic in_valid, dx, link_err;
  logic [6:0] station_addr;
  logic addr_valid, slave_enable;
  logic [23:0] vin;
  logic [135:0] out_image;
  logic led_power, led_online, led_offline, led_fault;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  // 50 MHz clock
  always #10 clock = ~clock;
  fpim_master_model master_u (.clock(clock), .in_image(in_image), .in_image_valid(in_valid),
    .dx_active(dx), .link_error(link_err));
  // short settle count keeps the start-up walk a few cycles long
  fpim_top #(.VIO_COUNT(24), .SETTLE_CNT(8)) dut_u (.clock(clock), .rst_b(rst_b),
    .tens_digit_switch(tens_sw), .ones_digit_switch(ones_sw), .in_image(in_image),
    .in_image_valid(in_valid), .dx_active(dx), .link_error(link_err), .vout(vout),
    .output_fault_flag(flag[0]), .input_fault_flag(flag[1]), .general_fault_flag(flag[2]),
    .diagnostic_flag(flag[3]), .run_flag(flag[4]), .station_addr(station_addr),
    .addr_valid(addr_valid), .slave_enable(slave_enable), .vin(vin), .out_image(out_image),
    .led_power(led_power), .led_online(led_online), .led_offline(led_offline),
    .led_fault(led_fault));
  // =====================================================
  // helpers
  task automatic check(input logic [135:0] seen, input logic [135:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // sample just after the edge so its updates have landed
  task automatic step();
    @(posedge clock);
    #1;
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // hang guard, far above the roughly 120 cycles the tests need
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      stop_test();
    end
  end
  // =====================================================
  // test sequence
  initial begin
    repeat (16) @(posedge clock);
    check(out_image, '0);
    rst_b <= 1'b1;
    // the capture state is entered at release edge 8, outputs follow at edge 9
    repeat (8) @(posedge clock);
    #1;
    check({addr_valid, slave_enable, led_power}, 3'b001);
    step();
    check(station_addr, 7'h24);
    check({addr_valid, slave_enable}, 2'b11);
    @(posedge clock);
    tens_sw <= 4'h5;
    ones_sw <= 4'h1;
    repeat (5) step();
    check(station_addr, 7'h24);
    // walking one across every basic output, all other bits must stay clear
    for (int n = 0; n < 24; n++) begin
      @(posedge clock);
      vout <= 24'h000001 << n;
      step();
      check(out_image, 136'h1 << n);
    end
    for (int i = 0; i < 5; i++) begin
      @(posedge clock);
      vout <= 24'hffffff;
      flag <= 5'h01 << i;
      step();
      check(out_image, {104'h0, 8'h01 << i, 24'hffffff});
    end
    master_u.set_link(1'b1, 1'b0);
    step();
    check({out_image[31:29], led_online, led_offline}, 5'b00110);
    master_u.send_frame(128'h77_c3105a, 0);
    #1;
    check(vin, 24'hc3105a);
    master_u.send_frame(128'h00_0a1000, 3);
    #1;
    check(vin[12], 1'b1);
    check(vin, 24'h0a1000);
    master_u.set_link(1'b0, 1'b0);
    step();
    check(vin, 24'h0);
    check({out_image[29], led_online, led_offline}, 3'b001);
    master_u.send_frame(128'hffffff, 0);
    #1;
    check(vin, 24'h0);
    master_u.set_link(1'b0, 1'b1);
    step();
    check(led_fault, 1'b1);
    master_u.set_link(1'b0, 1'b0);
    // second reset with an out-of-range tens digit; a changed setup only runs after a restart
    @(posedge clock);
    rst_b <= 1'b0;
    tens_sw <= 4'hc;
    ones_sw <= 4'h9;
    repeat (3) step();
    check(out_image, '0);
    check(led_fault, 1'b0);
    @(posedge clock);
    rst_b <= 1'b1;
    repeat (10) step();
    check(station_addr, ADDR_MAX);
    step();
    check(led_fault, 1'b1);
    stop_test();
  end
endmodule
